//--- common/color_path_pkg.sv
/*
 Shared constants and types for the pixel colour path.
 Assumes one pixel clock and four-bit colour codes (intensity, red,
 green, blue from bit 3 down).
*/
package color_path_pkg;
   localparam int CODE_W = 4;
   localparam int ENTRIES = 16;
   localparam int FIFO_DEPTH = 32;
   localparam int DE_DELAY = 3;
   localparam logic [3:0] CODE_ZERO = 4'h0;
   localparam logic [3:0] MASK_ALL = 4'hF;
   localparam logic [1:0] DE_DELAY_ZERO = 2'h0;
   typedef logic [CODE_W-1:0] code_t;
endpackage : color_path_pkg

//--- common/pixel_stream_if.sv
/*
 Valid and ready carrier for pixel codes between the path stages.
 Assumes both ends run on the same pixel clock.
*/
`timescale 1ns/10ps
interface pixel_stream_if;
   logic valid;
   logic ready;
   logic [3:0] code;
   logic border;
   modport source (output valid, output code, output border, input ready);
   modport sink (input valid, input code, input border, output ready);
endinterface : pixel_stream_if

//--- src/pixel_fifo.sv
/*
 Synchronous FIFO for pixel words with valid and ready on both sides.
 Assumes one clock; depth is a power of two.
*/
`timescale 1ns/10ps
module pixel_fifo #(
   parameter int WIDTH = 5,
   parameter int DEPTH = 32
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW:0] wr;
      logic [AW:0] rd;
      logic room;
   } fifo_s;
   fifo_s st;
   fifo_s next_st;
   logic [WIDTH-1:0] mem [DEPTH];
   logic do_wr;
   logic do_rd;

   // Ready is a stored flag so the top sees it straight from a flop
   assign in_ready = st.room;
   assign out_valid = (st.wr != st.rd);
   assign out_data = mem[st.rd[AW-1:0]];
   assign do_wr = in_valid && in_ready;
   assign do_rd = out_valid && out_ready;

   // Pointer updates
   always_comb begin
      next_st = st;
      if (do_wr) begin
         next_st.wr = st.wr + 1'b1;
      end
      if (do_rd) begin
         next_st.rd = st.rd + 1'b1;
      end
      // Full when pointers differ only in wrap bit
      next_st.room = !((next_st.wr[AW] != next_st.rd[AW])
                       && (next_st.wr[AW-1:0] == next_st.rd[AW-1:0]));
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         st <= '{wr: '0, rd: '0, room: 1'b1};
      end else begin
         st <= next_st;
      end
   end

   // Storage write
   always_ff @(posedge mclk) begin
      if (do_wr) begin
         mem[st.wr[AW-1:0]] <= in_data;
      end
   end
endmodule : pixel_fifo

//--- src/palette_border_color_path.sv
/*
 Final colour stage: pre-palette latch, index selector, 16-entry
 palette, pixel FIFO, post-palette register and edge colour selector.
 Assumes pixel inputs come from logic on mclk; the display sink may
 stall through out_ready, which back-pressures pix_ready.
 Assumes the host loads the palette after reset, since every entry
 resets to zero and the screen stays black until then.
*/
`timescale 1ns/10ps
module palette_border_color_path
   import color_path_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic pix_valid,
   output logic pix_ready,
   input wire color_path_pkg::code_t pix_code,
   input wire color_path_pkg::code_t compat_select,
   input wire logic compat_select_en,
   input wire logic display_enable,
   input wire logic blanking,
   input wire logic extended_display_modes,
   input wire color_path_pkg::code_t pixel_mask,
   input wire logic index_from_address,
   input wire color_path_pkg::code_t palette_address,
   input wire logic palette_write,
   input wire color_path_pkg::code_t palette_data,
   input wire color_path_pkg::code_t border_colour,
   input wire logic border_colour_load,
   output color_path_pkg::code_t rgbi_out,
   output logic rgbi_valid,
   input wire logic out_ready
);
   import color_path_pkg::*;

   // Stage registers: pre latch, border delay pipe, post register,
   // border colour latch and output register, all in one struct
   typedef struct packed {
      code_t pre;
      logic pre_valid;
      logic [DE_DELAY-1:0] border_pipe;
      code_t post;
      logic post_border;
      logic post_valid;
      code_t edge_latch;
      code_t out;
      logic out_valid;
   } path_s;

   path_s st;
   path_s next_st;
   // Palette storage, one colour code per entry
   code_t palette [ENTRIES];
   code_t index;
   code_t looked_up;
   logic advance;
   logic border_now;
   // Carriers into and out of the FIFO; border flag rides with each code
   pixel_stream_if fq ();
   pixel_stream_if fo ();
   // FIFO read word, split into flag and code below
   logic [CODE_W:0] fifo_out;

   // Flow control: the pre latch moves only when the FIFO has room.
   // The FIFO ready comes from a register inside it, so pix_ready
   // is a flop output and no loop runs through the sink.
   // Pipeline advances only when FIFO accepts
   assign advance = fq.ready;
   assign pix_ready = advance;
   // Border: display disabled but not blanking
   // Sampled every advance so it keeps step with the pixel codes
   assign border_now = !display_enable && !blanking;

   // Index selector. The address path lets software show any entry
   // on screen; the mask clears chosen code bits. Clearing bits with
   // an AND keeps the selector a single level of logic.
   always_comb begin
      if (index_from_address) begin
         index = palette_address;
      end else begin
         index = st.pre & pixel_mask;
      end
   end

   // Write bypass so a same-cycle write is seen at once
   // Without it the pixel in the lookup cycle shows the old colour
   always_comb begin
      if (palette_write && (palette_address == index)) begin
         looked_up = palette_data;
      end else begin
         looked_up = palette[index];
      end
   end

   // Palette storage written at the address register
   // Entries clear on reset; the host loads the mapping it wants
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < ENTRIES; i++) begin
            palette[i] <= CODE_ZERO;
         end
      end else if (palette_write) begin
         palette[palette_address] <= palette_data;
      end
   end

   // FIFO entry: looked-up colour plus border flag sampled two advances before that pixel's code.
   // Palette read happens here; the bypass puts a same-cycle write into this entry.
   // Border flag is the oldest pipe bit, so every pipe bit is used.
   assign fq.valid = st.pre_valid;
   assign fq.code = looked_up;
   assign fq.border = st.border_pipe[DE_DELAY-1];

   pixel_fifo #(
      .WIDTH(CODE_W + 1),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .mclk(mclk),
      .nrst(nrst),
      .in_valid(fq.valid),
      .in_ready(fq.ready),
      .in_data({fq.border, fq.code}),
      .out_valid(fo.valid),
      .out_ready(fo.ready),
      .out_data(fifo_out)
   );

   // Split FIFO word back into border flag and colour
   assign fo.border = fifo_out[CODE_W];
   assign fo.code = fifo_out[CODE_W-1:0];

   // Drain FIFO when post stage empty or moving on
   // Output stage load terms plus an empty post stage, so a held post is never overwritten
   assign fo.ready = !st.post_valid || !st.out_valid || out_ready;

   // Stage updates
   always_comb begin
      next_st = st;
      // Border colour latch, loaded by its strobe
      if (border_colour_load) begin
         next_st.edge_latch = border_colour;
      end
      // Pre latch and border pipe move only when the FIFO has room
      if (advance) begin
         // Merge compatibility select and latch
         next_st.pre_valid = pix_valid;
         next_st.border_pipe = {st.border_pipe[DE_DELAY-2:0], border_now};
         if (compat_select_en && border_now) begin
            next_st.pre = compat_select;
         end else begin
            next_st.pre = pix_code;
         end
      end
      // Output stage loads when empty or when the sink takes
      if (!st.out_valid || out_ready) begin
         next_st.out_valid = st.post_valid;
         if (st.post_border && extended_display_modes) begin
            next_st.out = st.edge_latch;
         end else begin
            next_st.out = st.post;
         end
         // Post register empties; refilled below if the FIFO hands over
         next_st.post_valid = 1'b0;
      end
      // FIFO hand-over into the post register wins over emptying
      if (fo.valid && fo.ready) begin
         // Post-palette register
         next_st.post = fo.code;
         next_st.post_border = fo.border;
         next_st.post_valid = 1'b1;
      end
   end

   // All stage registers clear together; rgbi_out and rgbi_valid read zero in reset
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from the output stage registers
   assign rgbi_out = st.out;
   assign rgbi_valid = st.out_valid;
endmodule : palette_border_color_path

//--- tb/color_path_chk.sv
/* Port checker for the colour path.
 Assumes it is bound to the top module. */
`timescale 1ns/10ps
module color_path_chk
   import color_path_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic pix_valid,
   input wire logic pix_ready,
   input wire logic rgbi_valid,
   input wire color_path_pkg::code_t rgbi_out,
   input wire logic out_ready
);
   int occ;
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   // Pixels taken but not yet delivered
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         occ <= 0;
      end else begin
         occ <= occ + (pix_valid & pix_ready) - (rgbi_valid & out_ready);
      end
   end
   property p_rst_out;
      $rose(nrst) |-> !rgbi_valid && rgbi_out == CODE_ZERO;
   endproperty
   a_rst_out: assert property (p_rst_out) else $error("reset out");
   property p_rst_ready; $rose(nrst) |-> pix_ready; endproperty
   a_rst_ready: assert property (p_rst_ready) else $error("ready");
   property p_hold_valid; rgbi_valid && !out_ready |=> rgbi_valid; endproperty
   a_hold_valid: assert property (p_hold_valid) else $error("drop");
   property p_hold_code;
      rgbi_valid && !out_ready |=> $stable(rgbi_out);
   endproperty
   a_hold_code: assert property (p_hold_code) else $error("code");
   property p_latency; pix_valid && pix_ready |-> ##[1:5] rgbi_valid; endproperty
   a_latency: assert property (p_latency) else $error("late");
   // FIFO only fills while the sink holds the output
   property p_fell;
      $fell(pix_ready) |-> $past(rgbi_valid) && !$past(out_ready);
   endproperty
   a_fell: assert property (p_fell) else $error("refused early");
   property p_full; !pix_ready |-> occ >= FIFO_DEPTH; endproperty
   a_full: assert property (p_full) else $error("not full");
   property p_empty; occ == 0 |-> !rgbi_valid; endproperty
   a_empty: assert property (p_empty) else $error("ghost");
endmodule : color_path_chk
bind palette_border_color_path color_path_chk chk (.mclk, .nrst, .pix_valid,
   .pix_ready, .rgbi_valid, .rgbi_out, .out_ready);

//--- tb/monitor_model.sv
/* Display monitor model that takes colour codes.
 Assumes the bench drives hold and slow. */
`timescale 1ns/10ps
module monitor_model (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic rgbi_valid,
   input wire logic [3:0] rgbi_out,
   input wire logic hold,
   input wire logic slow,
   output logic out_ready = 1'b0
);
   logic [3:0] got[$];
   logic tick = 1'b0;
   // Ready pattern, changed off the sampling edge
   always @(negedge mclk) begin
      tick <= !tick;
      out_ready <= !hold && (!slow || tick);
   end
   // Collect each accepted code
   always @(posedge mclk) begin
      if (!nrst) got.delete();
      else if (rgbi_valid && out_ready) got.push_back(rgbi_out);
   end
endmodule : monitor_model

//--- tb/tb.sv
/* Bench for the colour path with a monitor model.
 Assumes the checker binds itself to the design. */
`timescale 1ns/10ps
module tb;
   import color_path_pkg::*;
   logic mclk = 0, nrst = 0, pix_valid = 0, compat_select_en = 0, hold = 0;
   logic display_enable = 1, blanking = 0, extended_display_modes = 0;
   logic index_from_address = 0, palette_write = 0, border_colour_load = 0;
   logic pix_ready, rgbi_valid, out_ready, slow = 0;
   code_t pix_code = 0, compat_select = 0, pixel_mask = MASK_ALL, rgbi_out;
   code_t palette_address = 0, palette_data = 0, border_colour = 0;
   code_t pal[16] = '{default: 4'h0};
   int failures = 0, num_checks = 0, n;
   palette_border_color_path uut (.*);
   monitor_model mon (.*);
   // Pixel clock
   always #50 mclk = !mclk;
   task automatic check(input code_t got, input code_t exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : check
   task automatic send(input int c);
      @(negedge mclk);
      pix_valid = 1;
      pix_code = code_t'(c);
      while (!pix_ready) @(negedge mclk);
      @(posedge mclk);
   endtask : send
   task automatic get(input code_t exp);
      int i;
      for (i = 0; i < 300 && mon.got.size() == 0; i++) @(negedge mclk);
      check((i < 300) ? mon.got.pop_front() : 4'hX, exp);
   endtask : get
   task automatic wr(input int a, input int d);
      @(negedge mclk);
      pix_valid = 0;
      palette_address = code_t'(a);
      palette_data = code_t'(d);
      pal[a] = code_t'(d);
      palette_write = 1;
      @(negedge mclk);
      palette_write = 0;
   endtask : wr
   // Drop the pixel strobe at the falling edge after the take
   task automatic stop_px;
      @(negedge mclk);
      pix_valid = 0;
   endtask : stop_px
   task automatic px(input int c, input code_t exp);
      repeat (3) @(negedge mclk);
      send(c);
      stop_px;
      get(exp);
   endtask : px
   task automatic t_map;
      px(7, CODE_ZERO);
      for (n = 0; n < 16; n++) wr(n, 15 - n);
      for (n = 0; n < 16; n++) send(n);
      stop_px;
      for (n = 0; n < 16; n++) get(pal[n]);
      for (n = 0; n < 4; n++) begin
         pixel_mask = MASK_ALL ^ (4'h1 << n);
         px(15, pal[pixel_mask]);
      end
      pixel_mask = MASK_ALL;
      index_from_address = 1;
      palette_address = 4'h5;
      px(0, pal[5]);
      index_from_address = 0;
      $display("map test done");
   endtask : t_map
   task automatic t_border;
      border_colour = 4'hC;
      border_colour_load = 1;
      @(negedge mclk);
      border_colour_load = 0;
      display_enable = 0;
      extended_display_modes = 1;
      px(2, 4'hC);
      blanking = 1;
      px(2, pal[2]);
      blanking = 0;
      extended_display_modes = 0;
      px(2, pal[2]);
      compat_select = 4'h9;
      compat_select_en = 1;
      px(2, pal[9]);
      compat_select_en = 0;
      display_enable = 1;
      send(3);
      wr(3, 10);
      get(4'hA);
      for (n = 0; n < 16; n++) wr(n, n);
      $display("border test done");
   endtask : t_border
   task automatic t_fill;
      int k;
      n = 0;
      hold = 1;
      for (k = 0; k < 48; k++) begin
         @(negedge mclk);
         pix_valid = 1;
         pix_code = code_t'(n);
         if (pix_ready) n++;
      end
      check(code_t'(pix_ready), 4'h0);
      check(code_t'(n >= FIFO_DEPTH), 4'h1);
      wr(0, 0);
      hold = 0;
      slow = 1;
      for (k = 0; k < n; k++) get(code_t'(k));
      $display("fill test done");
   endtask : t_fill
   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : close_out
   // Watchdog
   initial begin
      #3000000;
      failures++;
      close_out;
   end
   // Main sequence
   initial begin
      repeat (5) @(negedge mclk);
      nrst = 1;
      t_map;
      t_border;
      t_fill;
      close_out;
   end
endmodule : tb
